// file: sim/dsrq_regs_tb.sv
// Self-checking bench for the software DMA request registers
`timescale 1ns/100ps
module dsrq_regs_tb;
   // ******************************************************
   // Stimulus, observation and bookkeeping
   // ******************************************************
   logic        clk_sys     = 1'b0;
   logic        rst         = 1'b1;
   logic [7:0]  reg_addr    = 8'h00;
   logic [31:0] reg_wdata   = 32'h0000_0000;
   logic        reg_wr      = 1'b0;
   logic        reg_rd      = 1'b0;
   logic        sel_single  = 1'b0;
   logic [15:0] ack_v       = 16'h0000;
   logic [15:0] done_v      = 16'h0000;
   logic [31:0] reg_rdata;
   logic [15:0] burst_req;
   logic [15:0] single_req;
   logic        operate;
   logic [31:0] rd_val;
   logic [7:0]  ofs;
   int          n_errors    = 0;
   int          check_count = 0;
   // Engine answers go only to the kind under test
   // no hardware request source
   wire  [15:0] b_ack   = sel_single ? 16'h0000 : ack_v;
   wire  [15:0] b_done  = sel_single ? 16'h0000 : done_v;
   wire  [15:0] s_ack   = sel_single ? ack_v : 16'h0000;
   wire  [15:0] s_done  = sel_single ? done_v : 16'h0000;
   wire  [15:0] req_sel = sel_single ? single_req : burst_req;
   wire  [15:0] req_oth = sel_single ? burst_req : single_req;

   dsrq_regs u_dsrq_regs (
      .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .burst_req(burst_req), .burst_ack(b_ack),
      .burst_done(b_done), .single_req(single_req), .single_ack(s_ack),
      .single_done(s_done), .operate(operate)
   );

   // 100 MHz system clock
   always #5 clk_sys = ~clk_sys;

   // ******************************************************
   // Bus and engine tasks
   // ******************************************************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   // Write lands at the edge that samples the strobe
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      #1;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   // One-cycle engine answer: ack or done on chosen numbers
   task automatic eng(input logic is_done, input logic [15:0] v);
      @(posedge clk_sys);
      if (is_done) done_v <= v;
      else ack_v <= v;
      @(posedge clk_sys);
      ack_v  <= 16'h0000;
      done_v <= 16'h0000;
      #1;
   endtask
   task automatic finish_test;
      $display("checks %0d, mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   // ******************************************************
   // Test sequence
   // ******************************************************
   initial begin
      repeat (12) @(posedge clk_sys);
      rst <= 1'b0;
      // Stopped circuit: request registers locked
      wr(dsrq_pkg::OFS_BURST_REQ, 32'h0000_0001);
      check({31'h0, operate}, 32'h0000_0000);
      check({16'h0, burst_req}, 32'h0000_0000);
      rd(dsrq_pkg::OFS_BURST_REQ, rd_val);
      check(rd_val, 32'h0000_0000);
      wr(dsrq_pkg::OFS_CONFIG, 32'h0000_0001);
      check({31'h0, operate}, 32'h0000_0001);
      rd(8'h0C, rd_val);
      check(rd_val, 32'h0000_0000);
      $display("test locked access done");
      // Same sequence for burst then single requests
      for (int k = 0; k < 2; k++) begin
         sel_single <= k[0];
         ofs = k ? dsrq_pkg::OFS_SINGLE_REQ : dsrq_pkg::OFS_BURST_REQ;
         rd(ofs, rd_val);
         check(rd_val, 32'h0000_0000);
         wr(ofs, 32'h0000_0000);
         rd(ofs, rd_val);
         check(rd_val, 32'h0000_0000);
         wr(ofs, 32'h0000_8001);
         check({16'h0, req_sel}, 32'h0000_8001);
         check({16'h0, req_oth}, 32'h0000_0000);
         rd(ofs, rd_val);
         check(rd_val, 32'h0000_8001);
         wr(ofs, 32'h0000_0000);
         rd(ofs, rd_val);
         check(rd_val, 32'h0000_8001);
         eng(1'b0, 16'h8001);
         check({16'h0, req_sel}, 32'h0000_0000);
         rd(ofs, rd_val);
         check(rd_val, 32'h0000_8001);
         eng(1'b1, 16'h0001);
         rd(ofs, rd_val);
         check(rd_val, 32'h0000_8000);
         eng(1'b1, 16'h8000);
         rd(ofs, rd_val);
         check(rd_val, 32'h0000_0000);
         $display("test request kind %0d done", k);
      end
      // Stopping the circuit hides a pending request
      wr(dsrq_pkg::OFS_SINGLE_REQ, 32'h0000_0002);
      wr(dsrq_pkg::OFS_CONFIG, 32'h0000_0000);
      rd(dsrq_pkg::OFS_SINGLE_REQ, rd_val);
      check(rd_val, 32'h0000_0000);
      wr(dsrq_pkg::OFS_BURST_REQ, 32'h0000_0004);
      check({16'h0, burst_req}, 32'h0000_0000);
      $display("test stop mid-request done");
      finish_test();
   end

   // Watchdog: the sequence needs about 80 cycles
   initial begin
      #100us;
      n_errors++;
      finish_test();
   end
endmodule

// file: verilog/dsrq_pkg.sv
// Constants for the software DMA request register block
package dsrq_pkg;
   // ******************************************************
   // Register map (byte addresses)
   // ******************************************************
   localparam int          ADDR_W         = 8;
   localparam int          DATA_W         = 32;
   localparam int          NUM_REQ        = 16;
   localparam logic [7:0]  OFS_BURST_REQ  = 8'h00;
   localparam logic [7:0]  OFS_SINGLE_REQ = 8'h04;
   localparam logic [7:0]  OFS_CONFIG     = 8'h08;
   // ******************************************************
   // Field positions and reset values
   // ******************************************************
   localparam int          CFG_OPERATE_BIT = 0;
   localparam logic [15:0] REQ_RESET       = 16'h0000;
   localparam logic [31:0] READ_IDLE       = 32'h0000_0000;
   // ******************************************************
   // Per-request tracker states
   // ******************************************************
   typedef enum logic [1:0] {
      DSRQ_IDLE,
      DSRQ_PEND,
      DSRQ_RUN
   } dsrq_state_t;
endpackage

// file: verilog/dsrq_regs.sv
// Software burst and single DMA request registers
`timescale 1ns/100ps
module dsrq_regs #(
   parameter int NUM_REQ = dsrq_pkg::NUM_REQ
) (
   // Clock and reset
   input  wire logic                          clk_sys,
   input  wire logic                          rst,
   // Register port
   input  wire logic [dsrq_pkg::ADDR_W-1:0]   reg_addr,
   input  wire logic [dsrq_pkg::DATA_W-1:0]   reg_wdata,
   input  wire logic                          reg_wr,
   input  wire logic                          reg_rd,
   output logic      [dsrq_pkg::DATA_W-1:0]   reg_rdata,
   // Engine handshake, burst
   output logic      [NUM_REQ-1:0]            burst_req,
   input  wire logic [NUM_REQ-1:0]            burst_ack,
   input  wire logic [NUM_REQ-1:0]            burst_done,
   // Engine handshake, single
   output logic      [NUM_REQ-1:0]            single_req,
   input  wire logic [NUM_REQ-1:0]            single_ack,
   input  wire logic [NUM_REQ-1:0]            single_done,
   // Global operate state
   output logic                               operate
);
   // ******************************************************
   // Address decode
   // ******************************************************
   wire logic               hit_burst;
   wire logic               hit_single;
   wire logic               hit_config;
   wire logic               wr_burst;
   wire logic               wr_single;
   wire logic               wr_config;
   wire logic [NUM_REQ-1:0] set_burst;
   wire logic [NUM_REQ-1:0] set_single;
   logic      [NUM_REQ-1:0] sw_burst_request_bit;
   logic      [NUM_REQ-1:0] sw_single_request_bit;
   logic      [NUM_REQ-1:0] burst_req_i;
   logic      [NUM_REQ-1:0] single_req_i;
   wire logic [dsrq_pkg::DATA_W-1:0] next_rdata;
   wire logic [dsrq_pkg::DATA_W-1:0] cfg_word;
   wire logic [dsrq_pkg::DATA_W-1:0] burst_word;
   wire logic [dsrq_pkg::DATA_W-1:0] single_word;

   // Register selects
   assign hit_burst  = (reg_addr == dsrq_pkg::OFS_BURST_REQ);
   assign hit_single = (reg_addr == dsrq_pkg::OFS_SINGLE_REQ);
   assign hit_config = (reg_addr == dsrq_pkg::OFS_CONFIG);
   assign wr_config  = reg_wr && hit_config;
   assign wr_burst   = reg_wr && hit_burst && operate;
   assign wr_single  = reg_wr && hit_single && operate;
   assign set_burst  = wr_burst ? reg_wdata[NUM_REQ-1:0] : '0;
   assign set_single = wr_single ? reg_wdata[NUM_REQ-1:0] : '0;

   // ******************************************************
   // Operate bit
   // ******************************************************
   // Config stays writable so software can turn the block on
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         operate <= 1'b0;
      end else if (wr_config) begin
         operate <= reg_wdata[dsrq_pkg::CFG_OPERATE_BIT];
      end
   end

   // ******************************************************
   // Per-request trackers
   // ******************************************************
   genvar gi;
   generate
      for (gi = 0; gi < NUM_REQ; gi++) begin : g_req
         dsrq_tracker u_burst (
            .clk_sys   (clk_sys),
            .rst       (rst),
            .set_req   (set_burst[gi]),
            .xfer_ack  (burst_ack[gi]),
            .xfer_done (burst_done[gi]),
            .req_out   (burst_req_i[gi]),
            .active    (sw_burst_request_bit[gi])
         );
         dsrq_tracker u_single (
            .clk_sys   (clk_sys),
            .rst       (rst),
            .set_req   (set_single[gi]),
            .xfer_ack  (single_ack[gi]),
            .xfer_done (single_done[gi]),
            .req_out   (single_req_i[gi]),
            .active    (sw_single_request_bit[gi])
         );

         // Burst side: raise, stay idle, wait for the engine
         a_burst_raise_each:
         assert property (@(posedge clk_sys) disable iff (rst)
            (wr_burst && reg_wdata[gi]
             && !(burst_req[gi] && burst_ack[gi]))
            |=> (burst_req[gi] && sw_burst_request_bit[gi]))
         else $error("burst request not raised by a one");

         a_burst_idle_stay:
         assert property (@(posedge clk_sys) disable iff (rst)
            (!sw_burst_request_bit[gi] && !(wr_burst && reg_wdata[gi]))
            |=> (!sw_burst_request_bit[gi] && !burst_req[gi]))
         else $error("burst request rose without a one written");

         a_burst_req_wait:
         assert property (@(posedge clk_sys) disable iff (rst)
            (burst_req[gi] && !burst_ack[gi]) |=> burst_req[gi])
         else $error("burst request dropped before the engine took it");

         // Burst side: running status until completion
         a_burst_ack_take:
         assert property (@(posedge clk_sys) disable iff (rst)
            (burst_req[gi] && burst_ack[gi])
            |=> (!burst_req[gi] && sw_burst_request_bit[gi]))
         else $error("burst request not handed over on acknowledge");

         a_burst_run_hold:
         assert property (@(posedge clk_sys) disable iff (rst)
            (sw_burst_request_bit[gi] && !burst_done[gi])
            |=> sw_burst_request_bit[gi])
         else $error("burst status fell while the transfer ran");

         a_burst_done_each:
         assert property (@(posedge clk_sys) disable iff (rst)
            (sw_burst_request_bit[gi] && !burst_req[gi] && burst_done[gi]
             && !(wr_burst && reg_wdata[gi])) |=> !sw_burst_request_bit[gi])
         else $error("burst status stayed after completion");

         a_burst_shows_run:
         assert property (@(posedge clk_sys) disable iff (rst)
            burst_req[gi] |-> sw_burst_request_bit[gi])
         else $error("burst request line up with status clear");

         // Single side: raise, stay idle, wait for the engine
         a_single_raise_each:
         assert property (@(posedge clk_sys) disable iff (rst)
            (wr_single && reg_wdata[gi]
             && !(single_req[gi] && single_ack[gi]))
            |=> (single_req[gi] && sw_single_request_bit[gi]))
         else $error("single request not raised by a one");

         a_single_idle_stay:
         assert property (@(posedge clk_sys) disable iff (rst)
            (!sw_single_request_bit[gi] && !(wr_single && reg_wdata[gi]))
            |=> (!sw_single_request_bit[gi] && !single_req[gi]))
         else $error("single request rose without a one written");

         a_single_req_wait:
         assert property (@(posedge clk_sys) disable iff (rst)
            (single_req[gi] && !single_ack[gi]) |=> single_req[gi])
         else $error("single request dropped before the engine took it");

         // Single side: running status until completion
         a_single_ack_take:
         assert property (@(posedge clk_sys) disable iff (rst)
            (single_req[gi] && single_ack[gi])
            |=> (!single_req[gi] && sw_single_request_bit[gi]))
         else $error("single request not handed over on acknowledge");

         a_single_run_hold:
         assert property (@(posedge clk_sys) disable iff (rst)
            (sw_single_request_bit[gi] && !single_done[gi])
            |=> sw_single_request_bit[gi])
         else $error("single status fell while the transfer ran");

         a_single_done_each:
         assert property (@(posedge clk_sys) disable iff (rst)
            (sw_single_request_bit[gi] && !single_req[gi] && single_done[gi]
             && !(wr_single && reg_wdata[gi])) |=> !sw_single_request_bit[gi])
         else $error("single status stayed after each completion");

         a_single_shows_run:
         assert property (@(posedge clk_sys) disable iff (rst)
            single_req[gi] |-> sw_single_request_bit[gi])
         else $error("single request line up with status clear");

         // A stopped block never starts a request
         a_stopped_stay_idle:
         assert property (@(posedge clk_sys) disable iff (rst)
            (!operate && !sw_burst_request_bit[gi]
             && !sw_single_request_bit[gi])
            |=> (!sw_burst_request_bit[gi] && !sw_single_request_bit[gi]))
         else $error("request raised while the block is stopped");
      end
   endgenerate

   // Request lines come straight from tracker flops
   assign burst_req  = burst_req_i;
   assign single_req = single_req_i;

   // ******************************************************
   // Read path
   // ******************************************************
   // request register reads give zero while stopped
   // upper bits read zero
   // Word images keep the unused upper bits at zero
   assign cfg_word    = {{(dsrq_pkg::DATA_W-1){1'b0}}, operate};
   assign burst_word  = {{(dsrq_pkg::DATA_W-NUM_REQ){1'b0}},
                         sw_burst_request_bit};
   assign single_word = {{(dsrq_pkg::DATA_W-NUM_REQ){1'b0}},
                         sw_single_request_bit};
   // Config answers even while stopped so the block can be woken
   assign next_rdata =
      (!reg_rd)  ? dsrq_pkg::READ_IDLE :
      hit_config ? cfg_word :
      (!operate) ? dsrq_pkg::READ_IDLE :
      hit_burst  ? burst_word :
      hit_single ? single_word :
      dsrq_pkg::READ_IDLE;

   // Read data valid one cycle after the strobe only
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         reg_rdata <= dsrq_pkg::READ_IDLE;
      end else begin
         reg_rdata <= next_rdata;
      end
   end

   // ******************************************************
   // Checks
   // ******************************************************
   a_burst_write_raise:
   assert property (@(posedge clk_sys) disable iff (rst)
      (wr_burst && reg_wdata[0] && !sw_burst_request_bit[0])
      |=> (burst_req[0] && sw_burst_request_bit[0]))
   else $error("burst write of one did not raise request");

   a_burst_zero_noop:
   assert property (@(posedge clk_sys) disable iff (rst)
      (wr_burst && !reg_wdata[0] && !sw_burst_request_bit[0]
       && !burst_ack[0]) |=> !sw_burst_request_bit[0])
   else $error("burst write of zero changed state");

   a_single_write_raise:
   assert property (@(posedge clk_sys) disable iff (rst)
      (wr_single && reg_wdata[1] && !sw_single_request_bit[1])
      |=> (single_req[1] && sw_single_request_bit[1]))
   else $error("single write of one did not raise request");

   a_burst_read_status:
   assert property (@(posedge clk_sys) disable iff (rst)
      (reg_rd && hit_burst && operate)
      |=> (reg_rdata[NUM_REQ-1:0] == $past(sw_burst_request_bit)))
   else $error("burst read did not show running state");

   a_single_read_status:
   assert property (@(posedge clk_sys) disable iff (rst)
      (reg_rd && hit_single && operate)
      |=> (reg_rdata[NUM_REQ-1:0] == $past(sw_single_request_bit)))
   else $error("single read did not show running state");

   a_single_done_clear:
   assert property (@(posedge clk_sys) disable iff (rst)
      (sw_single_request_bit[0] && !single_req[0] && single_done[0]
       && !set_single[0]) |=> !sw_single_request_bit[0])
   else $error("single status stayed after completion");

   a_stopped_no_write:
   assert property (@(posedge clk_sys) disable iff (rst)
      (!operate && reg_wr && hit_burst && !sw_burst_request_bit[2])
      |=> !sw_burst_request_bit[2])
   else $error("request register written while stopped");

   a_stopped_read_zero:
   assert property (@(posedge clk_sys) disable iff (rst)
      (!operate && reg_rd && (hit_burst || hit_single))
      |=> (reg_rdata == dsrq_pkg::READ_IDLE))
   else $error("request register readable while stopped");

   a_upper_read_zero:
   assert property (@(posedge clk_sys) disable iff (rst)
      $past(reg_rd) |-> (reg_rdata[dsrq_pkg::DATA_W-1:NUM_REQ] == '0))
   else $error("upper register bits not zero on read");

   a_read_quiet:
   assert property (@(posedge clk_sys) disable iff (rst)
      !reg_rd |=> (reg_rdata == dsrq_pkg::READ_IDLE))
   else $error("read data stood outside its read cycle");

   a_reset_clears:
   assert property (@(posedge clk_sys) disable iff (rst)
      $past(rst) |->
         (sw_burst_request_bit == dsrq_pkg::REQ_RESET[NUM_REQ-1:0]
          && sw_single_request_bit == dsrq_pkg::REQ_RESET[NUM_REQ-1:0]))
   else $error("request bits not clear after reset");

   a_operate_write:
   assert property (@(posedge clk_sys) disable iff (rst)
      wr_config |=> (operate == $past(reg_wdata[dsrq_pkg::CFG_OPERATE_BIT])))
   else $error("operate bit did not take the written value");
endmodule

// file: verilog/dsrq_tracker.sv
// One request tracker: raise, hand to engine, watch until done
`timescale 1ns/100ps
module dsrq_tracker (
   // Clock and reset
   input  wire logic clk_sys,
   input  wire logic rst,
   // Software side
   input  wire logic set_req,
   // Engine side
   input  wire logic xfer_ack,
   input  wire logic xfer_done,
   output logic      req_out,
   output logic      active
);
   dsrq_pkg::dsrq_state_t state;
   dsrq_pkg::dsrq_state_t next_state;

   // Next state; a new set while running is held as one request
   always_comb begin
      next_state = state;
      case (state)
         dsrq_pkg::DSRQ_IDLE: begin
            if (set_req) begin
               next_state = dsrq_pkg::DSRQ_PEND;
            end
         end
         dsrq_pkg::DSRQ_PEND: begin
            if (xfer_ack) begin
               next_state = dsrq_pkg::DSRQ_RUN;
            end
         end
         dsrq_pkg::DSRQ_RUN: begin
            // Set wins over completion so the event is kept
            if (set_req) begin
               next_state = dsrq_pkg::DSRQ_PEND;
            end else if (xfer_done) begin
               next_state = dsrq_pkg::DSRQ_IDLE;
            end
         end
         default: next_state = dsrq_pkg::DSRQ_IDLE;
      endcase
   end

   // State and registered outputs
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state   <= dsrq_pkg::DSRQ_IDLE;
         req_out <= 1'b0;
         active  <= 1'b0;
      end else begin
         state   <= next_state;
         req_out <= (next_state == dsrq_pkg::DSRQ_PEND);
         active  <= (next_state != dsrq_pkg::DSRQ_IDLE);
      end
   end
endmodule
